// [rtl/cdpm_ctrl.sv]
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "cdpm_params.svh"
// Contract
// - divider changes only on apply code write
// - selection held pending until apply
// - codes 0..5 divide by 128..4
// - stop bit enters deep sleep
// - idle bit enters cpu halt
// - port1 wake enable per pin
// - port0 pins always wake
// - wake on either edge
// - deep sleep stops the fast oscillator
// - slow oscillator runs if watchdog always-on
// - deep sleep leaves only on pins
// - halt keeps system clock running
// - halt also leaves on enabled interrupt
// - hardware clears stop bit on wake
// - hardware clears idle bit on wake
// - wake returns to normal mode
// - stop wake waits 64 fast plus 5 slow
// - pin wake raises its request flag
// - deep sleep retains all registers
// - reset enters normal mode
// - divided clock is 32MHz fast oscillator
// - halt gates only cpu clock
module cdpm_ctrl
  import cdpm_pkg::*;
#(
  parameter int PinCount = 8
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [9:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  input wire logic [PinCount-1:0] port0Pins,
  input wire logic [PinCount-1:0] port1Pins,
  input wire logic irqPending,
  input wire logic watchdogAlwaysOn,
  input wire logic fastOscTick,
  input wire logic slowOscTick,
  output logic cpuClkEn,
  output logic cpuClkTick,
  output logic periphClkEn,
  output logic fastOscRun,
  output logic slowOscRun,
  output logic pinWakeFlag,
  output logic [2:0] activeDivider,
  output logic [1:0] modeState
);
  localparam int FastWake = `CDPM_FAST_WAKE_CLOCKS;
  localparam int SlowWake = `CDPM_SLOW_WAKE_CLOCKS;

  function automatic logic [6:0] divLimit(input logic [2:0] code);
    case (code)
      3'h0: divLimit = 7'h7F;
      3'h1: divLimit = 7'h3F;
      3'h2: divLimit = 7'h1F;
      3'h3: divLimit = 7'h0F;
      3'h4: divLimit = 7'h07;
      3'h5: divLimit = 7'h03;
      default: divLimit = 7'h7F;
    endcase
  endfunction

  logic [PinCount-1:0] p0Meta_q, p0Sync_q, p0Last_q;
  logic [PinCount-1:0] p1Meta_q, p1Sync_q, p1Last_q;
  logic [2:0] pendDiv_q;
  logic [2:0] actDiv_q;
  logic [7:0] p1Wake_q;
  logic stop_q, idle_q, flag_q;
  logic wakeFlag_q;
  logic ack_q;
  logic [31:0] datO_q;
  cdpm_mode_t mode_q, mode_d;
  logic [6:0] fastCnt_q;
  logic [2:0] slowCnt_q;
  logic [6:0] divCnt_q;
  logic tick_q;
  logic [1:0] prime_q;

  wire busReq = wbCyc && wbStb && !ack_q;
  wire [7:0] regIdx = wbAdr[9:2];
  wire wrEn = busReq && wbWe && wbSel[0] && clkEn;
  wire hitPcon = regIdx == `CDPM_IDX_POWER_CONTROL;
  wire hitP1w = regIdx == `CDPM_IDX_PORT1_WAKE;
  wire hitSel = regIdx == `CDPM_IDX_DIV_SELECT;
  wire hitCmd = regIdx == `CDPM_IDX_APPLY_CMD;
  // reset zeros would look like a change on every high pin, so edges
  // count only once the pin pipeline holds real samples
  wire primed = prime_q == 2'h3;
  // port0 always enabled, port1 gated, any edge
  wire [PinCount-1:0] p0Edge = (p0Sync_q ^ p0Last_q) & {PinCount{primed}};
  wire [PinCount-1:0] p1Edge = (p1Sync_q ^ p1Last_q) & p1Wake_q[PinCount-1:0]
    & {PinCount{primed}};
  wire pinWake = |p0Edge || |p1Edge;
  // only pins leave stop, interrupts also leave idle
  wire stopWake = (mode_q == CDPM_STOP) && pinWake;
  wire idleWake = (mode_q == CDPM_IDLE) && (pinWake || irqPending);
  wire warmDone = (fastCnt_q == 7'(FastWake)) && (slowCnt_q == 3'(SlowWake));
  wire [31:0] rdData =
    hitPcon ? {29'h0, flag_q, stop_q, idle_q} :
    hitP1w ? {24'h0, p1Wake_q} :
    hitSel ? {29'h0, pendDiv_q} : 32'h0;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      p0Meta_q <= '0;
      p0Sync_q <= '0;
      p0Last_q <= '0;
      p1Meta_q <= '0;
      p1Sync_q <= '0;
      p1Last_q <= '0;
      prime_q <= 2'h0;
    end
    else if (clkEn)
    begin
      p0Meta_q <= port0Pins;
      p0Sync_q <= p0Meta_q;
      p0Last_q <= p0Sync_q;
      p1Meta_q <= port1Pins;
      p1Sync_q <= p1Meta_q;
      p1Last_q <= p1Sync_q;
      if (prime_q != 2'h3)
        prime_q <= prime_q + 2'h1;
    end
  end

  // bus slave: one-cycle ack, unmapped reads zero, writes ignored
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack_q <= 1'b0;
      datO_q <= 32'h0;
    end
    else if (clkEn)
    begin
      ack_q <= busReq;
      datO_q <= busReq ? rdData : datO_q;
    end
  end

  // registers keep their values in every mode
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pendDiv_q <= `CDPM_DIV_SELECT_RESET;
      actDiv_q <= `CDPM_DIV_SELECT_RESET;
      p1Wake_q <= `CDPM_PORT1_WAKE_RESET;
      flag_q <= 1'b0;
    end
    else if (wrEn)
    begin
      if (hitSel)
        pendDiv_q <= wbDatI[2:0];
      if (hitCmd && wbDatI[7:0] == `CDPM_APPLY_CODE)
        actDiv_q <= pendDiv_q;
      if (hitP1w)
        p1Wake_q <= wbDatI[7:0];
      if (hitPcon)
        flag_q <= wbDatI[`CDPM_POWER_CONTROL_FLAG_BIT];
    end
  end

  // hardware clear of mode bits on wake
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stop_q <= 1'b0;
      idle_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (mode_q == CDPM_WARMUP || idleWake)
      begin
        stop_q <= 1'b0;
        idle_q <= 1'b0;
      end
      else if (wrEn && hitPcon && mode_q == CDPM_NORMAL)
      begin
        stop_q <= wbDatI[`CDPM_POWER_CONTROL_STOP_BIT];
        idle_q <= wbDatI[`CDPM_POWER_CONTROL_IDLE_BIT];
      end
    end
  end

  // mode sequence; stop wins over idle
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      CDPM_NORMAL:
        if (stop_q)
          mode_d = CDPM_STOP;
        else if (idle_q)
          mode_d = CDPM_IDLE;
      CDPM_IDLE:
        if (idleWake)
          mode_d = CDPM_NORMAL;
      CDPM_STOP:
        if (stopWake)
          mode_d = CDPM_WARMUP;
      CDPM_WARMUP:
        if (warmDone)
          mode_d = CDPM_NORMAL;
      default:
        mode_d = CDPM_NORMAL;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      mode_q <= CDPM_NORMAL;
    else if (clkEn)
      mode_q <= mode_d;
  end

  // count fast then slow oscillator ticks after stop wake
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fastCnt_q <= 7'h0;
      slowCnt_q <= 3'h0;
    end
    else if (clkEn)
    begin
      // cleared outside warmup only while enabled, so a frozen block holds
      if (mode_q != CDPM_WARMUP)
      begin
        fastCnt_q <= 7'h0;
        slowCnt_q <= 3'h0;
      end
      else if (fastCnt_q != 7'(FastWake))
        fastCnt_q <= fastOscTick ? fastCnt_q + 7'h1 : fastCnt_q;
      else if (slowCnt_q != 3'(SlowWake))
        slowCnt_q <= slowOscTick ? slowCnt_q + 3'h1 : slowCnt_q;
    end
  end

  // sticky wake request, cleared by reading power control
  always_ff @(posedge clk)
  begin
    if (rst)
      wakeFlag_q <= 1'b0;
    else if (clkEn)
    begin
      if (stopWake || (mode_q == CDPM_IDLE && pinWake))
        wakeFlag_q <= 1'b1;
      else if (busReq && !wbWe && hitPcon)
        wakeFlag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      divCnt_q <= 7'h0;
      tick_q <= 1'b0;
    end
    else if (clkEn)
    begin
      tick_q <= 1'b0;
      if (fastOscTick && fastOscRun)
      begin
        if (divCnt_q >= divLimit(actDiv_q))
        begin
          divCnt_q <= 7'h0;
          tick_q <= 1'b1;
        end
        else
          divCnt_q <= divCnt_q + 7'h1;
      end
    end
  end

  assign wbAck = ack_q;
  assign wbDatO = datO_q;
  assign cpuClkEn = mode_q == CDPM_NORMAL;
  assign cpuClkTick = tick_q && cpuClkEn;
  assign periphClkEn = mode_q == CDPM_NORMAL || mode_q == CDPM_IDLE;
  assign fastOscRun = mode_q != CDPM_STOP;
  assign slowOscRun = mode_q != CDPM_STOP || watchdogAlwaysOn;
  assign pinWakeFlag = wakeFlag_q;
  assign activeDivider = actDiv_q;
  assign modeState = mode_q;

  a_apply_divider: assert property (@(posedge clk) disable iff (rst)
    wrEn && hitCmd && wbDatI[7:0] == 8'h69 |=> actDiv_q == $past(pendDiv_q))
    else $error("divider not applied");
  a_pending_hold: assert property (@(posedge clk) disable iff (rst)
    !(wrEn && hitCmd) |=> $stable(actDiv_q))
    else $error("divider changed without apply");
  a_bad_apply: assert property (@(posedge clk) disable iff (rst)
    wrEn && hitCmd && wbDatI[7:0] != 8'h69 |=> $stable(actDiv_q))
    else $error("non apply code changed divider");
  a_stop_osc: assert property (@(posedge clk) disable iff (rst)
    mode_q == CDPM_STOP |-> !fastOscRun && !periphClkEn && !cpuClkEn)
    else $error("stop mode clocks running");
  a_slow_osc: assert property (@(posedge clk) disable iff (rst)
    mode_q == CDPM_STOP && !watchdogAlwaysOn |-> !slowOscRun)
    else $error("slow oscillator running in stop");
  a_stop_irq: assert property (@(posedge clk) disable iff (rst)
    mode_q == CDPM_STOP && clkEn && !pinWake |=> mode_q == CDPM_STOP)
    else $error("stop left without pin");
  a_idle_wake: assert property (@(posedge clk) disable iff (rst)
    mode_q == CDPM_IDLE && clkEn && irqPending |=> mode_q == CDPM_NORMAL && !idle_q)
    else $error("idle not left on interrupt");
  a_idle_periph: assert property (@(posedge clk) disable iff (rst)
    mode_q == CDPM_IDLE |-> periphClkEn && fastOscRun && !cpuClkEn)
    else $error("idle gating wrong");
  a_warm_exit: assert property (@(posedge clk) disable iff (rst)
    mode_q == CDPM_WARMUP && !warmDone && clkEn |=> mode_q == CDPM_WARMUP)
    else $error("warmup ended early");
  a_stop_clear: assert property (@(posedge clk) disable iff (rst)
    $fell(mode_q == CDPM_WARMUP) |-> !stop_q && mode_q == CDPM_NORMAL)
    else $error("stop bit not cleared");
  a_stop_wake: assert property (@(posedge clk) disable iff (rst)
    mode_q == CDPM_STOP && clkEn && pinWake |=> mode_q == CDPM_WARMUP)
    else $error("stop not left on pin change");
  a_idle_clear: assert property (@(posedge clk) disable iff (rst)
    mode_q == CDPM_IDLE && clkEn && (pinWake || irqPending) |=> !idle_q)
    else $error("idle bit not cleared");
  a_wake_flag: assert property (@(posedge clk) disable iff (rst)
    clkEn && stopWake |=> wakeFlag_q)
    else $error("wake flag not set");
  a_run_clocks: assert property (@(posedge clk) disable iff (rst)
    mode_q == CDPM_NORMAL || mode_q == CDPM_IDLE |-> fastOscRun && slowOscRun && periphClkEn)
    else $error("clocks stopped while awake");
  a_reset_normal: assert property (@(posedge clk)
    $fell(rst) |-> mode_q == CDPM_NORMAL && actDiv_q == `CDPM_DIV_SELECT_RESET && !stop_q)
    else $error("reset did not give normal mode");
  a_warm_start: assert property (@(posedge clk) disable iff (rst)
    $rose(mode_q == CDPM_WARMUP) |-> fastCnt_q == 7'h0 && slowCnt_q == 3'h0)
    else $error("warmup counters not cleared");
endmodule // cdpm_ctrl

// [rtl/cdpm_params.svh]
`ifndef CDPM_PARAMS_SVH
`define CDPM_PARAMS_SVH
// register indices (printed offsets); byte address is four times the index
`define CDPM_IDX_POWER_CONTROL 8'h87
`define CDPM_IDX_PORT1_WAKE 8'h91
`define CDPM_IDX_DIV_SELECT 8'hE5
`define CDPM_IDX_APPLY_CMD 8'hE6
`define CDPM_APPLY_CODE 8'h69
`define CDPM_APPLY_RESET 8'h00
`define CDPM_DIV_SELECT_RESET 3'h7
`define CDPM_PORT1_WAKE_RESET 8'h00
`define CDPM_POWER_CONTROL_IDLE_BIT 0
`define CDPM_POWER_CONTROL_STOP_BIT 1
`define CDPM_POWER_CONTROL_FLAG_BIT 2
`define CDPM_FAST_WAKE_CLOCKS 64
`define CDPM_SLOW_WAKE_CLOCKS 5
`define CDPM_FAST_OSC_MHZ 32
`define CDPM_CLK_MHZ 250
`endif

// [rtl/cdpm_pkg.sv]
package cdpm_pkg;
  typedef enum logic [1:0] {
    CDPM_NORMAL = 2'h0,
    CDPM_IDLE = 2'h1,
    CDPM_STOP = 2'h3,
    CDPM_WARMUP = 2'h2
  } cdpm_mode_t;
endpackage

// [tb/cdpm_ctrl_tb_top.sv]
`timescale 1ns/1ps
`include "cdpm_params.svh"
module cdpm_ctrl_tb_top
  import cdpm_pkg::*;
;
  logic clk, rst, clkEn, wbCyc, wbStb, wbWe, wbAck, irqPending, watchdogAlwaysOn;
  logic fastOscTick, slowOscTick, cpuClkEn, cpuClkTick, periphClkEn, fastOscRun;
  logic slowOscRun, pinWakeFlag;
  logic [9:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatI, wbDatO, q, junk;
  logic [7:0] port0Pins, port1Pins;
  logic [2:0] activeDivider, expDiv;
  logic [1:0] modeState;
  int error_cnt, num_checks, seed, b, n;
  cdpm_ctrl #(.PinCount(8)) dut_u (.clk, .rst, .clkEn, .wbCyc, .wbStb, .wbWe, .wbAdr,
    .wbSel, .wbDatI, .wbDatO, .wbAck, .port0Pins, .port1Pins, .irqPending,
    .watchdogAlwaysOn, .fastOscTick, .slowOscTick, .cpuClkEn, .cpuClkTick,
    .periphClkEn, .fastOscRun, .slowOscRun, .pinWakeFlag, .activeDivider, .modeState);
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // classic single cycle; the bench never assumes the ack latency
  task automatic wb(input logic we, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'h0};
    wbDatI <= d;
    do @(posedge clk); while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic ticks(input int f, input int s);
    repeat (f) @(posedge clk) fastOscTick <= 1'b1;
    @(posedge clk) fastOscTick <= 1'b0;
    repeat (s) @(posedge clk) slowOscTick <= 1'b1;
    @(posedge clk) slowOscTick <= 1'b0;
  endtask
  task automatic waitMode(input logic [1:0] m);
    n = 0;
    while (modeState !== m && n < 40)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    {wbCyc, wbStb, wbWe, irqPending, watchdogAlwaysOn, fastOscTick, slowOscTick} = '0;
    {wbAdr, wbDatI, port1Pins} = '0;
    wbSel = 4'hF;
    port0Pins = 8'hFF;
    clkEn = 1'b1;
    seed = 72;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, `CDPM_IDX_DIV_SELECT, 0);
    chk(q, 32'h7);
    wb(1'b0, `CDPM_IDX_PORT1_WAKE, 0);
    chk(q, 32'h0);
    wb(1'b0, `CDPM_IDX_APPLY_CMD, 0);
    chk(q, 32'h0);
    wb(1'b0, 8'h10, 0);
    chk(q, 32'h0);
    chk({activeDivider, modeState}, {3'h7, CDPM_NORMAL});
    $display("reset test done");
    expDiv = 3'h7;
    for (int c = 0; c < 6; c++)
    begin
      wb(1'b1, `CDPM_IDX_DIV_SELECT, c);
      wb(1'b0, `CDPM_IDX_DIV_SELECT, 0);
      chk(q, c);
      chk(activeDivider, expDiv);
      junk = $random(seed) & 32'hFE;
      wb(1'b1, `CDPM_IDX_APPLY_CMD, junk);
      chk(activeDivider, expDiv);
      wb(1'b1, `CDPM_IDX_APPLY_CMD, `CDPM_APPLY_CODE);
      expDiv = c[2:0];
      @(posedge clk);
      chk(activeDivider, expDiv);
    end
    n = 0;
    fastOscTick <= 1'b1;
    repeat (17)
    begin
      @(posedge clk);
      n += cpuClkTick;
    end
    fastOscTick <= 1'b0;
    chk(n, 4);
    $display("divider test done");
    wb(1'b1, `CDPM_IDX_POWER_CONTROL, 32'h05);
    @(posedge clk);
    chk({modeState, cpuClkEn, periphClkEn, fastOscRun}, {CDPM_IDLE, 3'h3});
    irqPending <= 1'b1;
    waitMode(CDPM_NORMAL);
    irqPending <= 1'b0;
    chk(modeState, CDPM_NORMAL);
    wb(1'b0, `CDPM_IDX_POWER_CONTROL, 0);
    chk(q, 32'h04);
    $display("idle test done");
    for (int w = 0; w < 2; w++)
    begin
      b = $unsigned($random(seed)) % 8;
      watchdogAlwaysOn <= 1'($random(seed));
      wb(1'b1, `CDPM_IDX_PORT1_WAKE, 32'h1 << b);
      wb(1'b1, `CDPM_IDX_POWER_CONTROL, 32'h06);
      @(posedge clk);
      chk({modeState, fastOscRun, periphClkEn}, {CDPM_STOP, 2'h0});
      chk(slowOscRun, watchdogAlwaysOn);
      irqPending <= 1'b1;
      port1Pins[(b + 1) % 8] <= ~port1Pins[(b + 1) % 8];
      repeat (8) @(posedge clk);
      chk(modeState, CDPM_STOP);
      irqPending <= 1'b0;
      // port0 starts high so its wake here is a falling edge
      if (w == 0)
        port1Pins[b] <= ~port1Pins[b];
      else
        port0Pins[b] <= ~port0Pins[b];
      waitMode(CDPM_WARMUP);
      chk(modeState, CDPM_WARMUP);
      ticks(63, 0);
      chk(modeState, CDPM_WARMUP);
      ticks(1, 4);
      chk(modeState, CDPM_WARMUP);
      ticks(0, 1);
      waitMode(CDPM_NORMAL);
      chk({modeState, pinWakeFlag}, {CDPM_NORMAL, 1'b1});
      wb(1'b0, `CDPM_IDX_POWER_CONTROL, 0);
      chk(q, 32'h04);
      wb(1'b0, `CDPM_IDX_DIV_SELECT, 0);
      chk({q[2:0], activeDivider, pinWakeFlag}, {expDiv, expDiv, 1'b0});
      $display("stop wake test %0d done", w);
    end
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk({activeDivider, modeState}, {3'h7, CDPM_NORMAL});
    wb(1'b0, `CDPM_IDX_POWER_CONTROL, 0);
    chk(q, 32'h0);
    $display("second reset test done");
    report_and_stop();
  end
endmodule // cdpm_ctrl_tb_top
